//--- axil_slave.sv
// AXI4-Lite register slave handshake for the pacing block
`timescale 1ns/1ps
module axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [11:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_have_reg;
  logic w_have_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;
  assign wr_strb = wstrb_reg;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Write channel capture, response after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'h0;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- conv_pacing.sv
// Conversion pacing controller for the decimation filter chain
// Function
// - Data-ready falls once per conversion period
// - Settled after first conversion on channel
// - Period already includes post-processing time
// - Period 32, 352 or 320 times divider, fixed for post filters
// - Divider is an unsigned 11-bit value
// - Settled rate holds for repeat and single
// - Input step never restarts conversion pacing
// - Sinc4 needs 3, sinc3 needs 2 conversions
// - Asynchronous step adds one more conversion
// - Code 0011 adds notch at six fifths
// - Periods counted in 76.8 kHz main clock
// - Sinc4 types clamp divider above ten
// - Filter type resets to plain sinc3
`timescale 1ns/1ps
`include "pacing_defs.svh"
module conv_pacing
  import pacing_pkg::*;
#(
  parameter int MCLK_DIV = `MCLK_DIV,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] sample_data,
  output logic data_ready_n,
  output logic extra_notch_option
);
  // ****************************************
  // Functions
  // ****************************************
  // Settled period in main-clock cycles; post-processing is already inside it
  function automatic logic [15:0] period_of(input filter_type_e ft, input logic [10:0] div);
    logic [10:0] d;
    logic [15:0] p;
    d = (div == 11'h000) ? 11'h001 : div;
    if ((ft == FT_SINC4 || ft == FT_SINC4_AVG) && d > `DIV_MAX_SINC4) begin
      d = `DIV_MAX_SINC4;
    end
    unique case (ft)
      FT_SINC4, FT_SINC3, FT_SINC3_NOTCH: p = 16'(`MUL_STD * {5'h00, d});
      FT_SINC4_AVG: p = 16'(`MUL_AVG4 * {5'h00, d});
      FT_SINC3_AVG: p = 16'(`MUL_AVG3 * {5'h00, d});
      FT_POST1: p = `POST1_CYC;
      FT_POST2: p = `POST2_CYC;
      FT_POST3: p = `POST3_CYC;
      FT_POST4: p = `POST4_CYC;
      default: p = 16'(`MUL_STD * {5'h00, d});
    endcase
    return p;
  endfunction

  function automatic settle_info_s settle_of(input filter_type_e ft);
    settle_info_s s;
    s = '{settle_min: 3'h2, settle_max: 3'h3, notch_extra: 1'b0};
    unique case (ft)
      FT_SINC4: s = '{settle_min: 3'h3, settle_max: 3'h4, notch_extra: 1'b0};
      FT_SINC3: s = '{settle_min: 3'h2, settle_max: 3'h3, notch_extra: 1'b0};
      FT_SINC3_NOTCH: s = '{settle_min: 3'h2, settle_max: 3'h3, notch_extra: 1'b1};
      FT_SINC4_AVG, FT_SINC3_AVG: s = '{settle_min: 3'h1, settle_max: 3'h2, notch_extra: 1'b0};
      FT_POST1, FT_POST2, FT_POST3, FT_POST4: s = '{settle_min: 3'h0, settle_max: 3'h1, notch_extra: 1'b0};
      default: s = '{settle_min: 3'h2, settle_max: 3'h3, notch_extra: 1'b0};
    endcase
    return s;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] type_reg;
  logic enable_reg;
  logic [10:0] rate_divider_reg;
  logic [15:0] seq_reg;
  logic [2:0] settle_cnt_reg;
  logic settled_reg;
  logic [15:0] period_reg;
  logic [15:0] mcnt_reg;
  localparam int PW = $clog2(MCLK_DIV + 1);
  logic [PW-1:0] pre_reg;
  logic mclk_tick;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic conv_done;
  logic step_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  result_s fifo_out;
  result_s fifo_in;
  filter_type_e cur_type;
  settle_info_s cur_settle;
  logic [15:0] cur_period;

  assign cur_type = filter_type_e'(type_reg);
  assign cur_settle = settle_of(cur_type);
  assign cur_period = period_of(cur_type, rate_divider_reg);
  assign extra_notch_option = cur_settle.notch_extra;

  axil_slave u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
  );

  // ****************************************
  // Register writes
  // ****************************************
  assign wr_ok = (wr_addr == `REG_CTRL_OFF) || (wr_addr == `REG_DIV_OFF);
  assign step_wr = wr_en && wr_addr == `REG_CTRL_OFF && wr_strb[0] && wr_data[`CTRL_STEP_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      type_reg <= `TYPE_RESET;
      enable_reg <= 1'b0;
      rate_divider_reg <= `DIV_RESET;
    end else if (wr_en) begin
      if (wr_addr == `REG_CTRL_OFF && wr_strb[0]) begin
        type_reg <= wr_data[`CTRL_TYPE_LSB +: 4];
        enable_reg <= wr_data[`CTRL_EN_BIT];
      end
      if (wr_addr == `REG_DIV_OFF) begin
        if (wr_strb[0]) rate_divider_reg[7:0] <= wr_data[7:0];
        if (wr_strb[1]) rate_divider_reg[10:8] <= wr_data[10:8];
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h00000000;
    unique case (rd_addr)
      `REG_CTRL_OFF: rd_data = {27'h0000000, enable_reg, type_reg};
      `REG_DIV_OFF: rd_data = {21'h000000, rate_divider_reg};
      `REG_STAT_OFF: rd_data = {20'h00000, fifo_out_valid, extra_notch_option, settled_reg,
                                settle_cnt_reg, cur_settle.settle_max, cur_settle.settle_min};
      `REG_PERIOD_OFF: rd_data = {16'h0000, period_reg};
      `REG_RESULT_OFF: rd_data = fifo_out.data;
      `REG_COUNT_OFF: rd_data = {16'h0000, fifo_out.seq};
      default: rd_ok = 1'b0;
    endcase
  end

  // ****************************************
  // Main clock enable, 76.8 kHz
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= '0;
    end else if (pre_reg == PW'(MCLK_DIV - 1)) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end
  assign mclk_tick = (pre_reg == PW'(MCLK_DIV - 1));

  // ****************************************
  // Conversion period counter
  // ****************************************
  // Free-running while enabled; an input step does not touch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcnt_reg <= 16'h0001;
      period_reg <= `MUL_STD;
    end else if (!enable_reg) begin
      mcnt_reg <= 16'h0001;
    end else if (mclk_tick) begin
      if (mcnt_reg >= period_reg) begin
        mcnt_reg <= 16'h0001;
        period_reg <= cur_period;
      end else begin
        mcnt_reg <= mcnt_reg + 16'h0001;
      end
    end
  end
  assign conv_done = enable_reg && mclk_tick && (mcnt_reg >= period_reg);

  // Data ready low for one main-clock period after each conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ready_n <= 1'b1;
    end else if (conv_done) begin
      data_ready_n <= 1'b0;
    end else if (mclk_tick) begin
      data_ready_n <= 1'b1;
    end
  end

  // ****************************************
  // Step settling tracker
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_reg <= 3'h0;
      settled_reg <= 1'b1;
    end else if (step_wr) begin
      settle_cnt_reg <= wr_data[`CTRL_ASYNC_BIT] ? cur_settle.settle_max : cur_settle.settle_min;
      settled_reg <= 1'b0;
    end else if (conv_done && !settled_reg) begin
      if (settle_cnt_reg == 3'h0) begin
        settled_reg <= 1'b1;
      end else begin
        settle_cnt_reg <= settle_cnt_reg - 3'h1;
      end
    end
  end

  // ****************************************
  // Result FIFO
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_reg <= 16'h0000;
    end else if (conv_done) begin
      seq_reg <= seq_reg + 16'h0001;
    end
  end
  assign fifo_in = '{data: sample_data, seq: seq_reg};

  result_fifo #(.WIDTH($bits(result_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk), .aresetn(aresetn),
    .in_data(fifo_in), .in_valid(conv_done), .in_ready(fifo_in_ready),
    .out_data(fifo_out), .out_valid(fifo_out_valid),
    .out_ready(rd_en && rd_addr == `REG_COUNT_OFF)
  );

  // ****************************************
  // Checks
  // ****************************************
  AST_DRDY_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done |=> !data_ready_n) else $error("data ready did not fall");
  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done |=> (mcnt_reg == 16'h0001 && period_reg == $past(cur_period))) else $error("no reload");
  AST_PERIOD_MIN: assert property (@(posedge aclk) disable iff (!aresetn)
    period_reg >= 16'h0020) else $error("period below one divider step");
  AST_SINC4_CLAMP: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_type == FT_SINC4) |-> cur_period <= 16'h0140) else $error("sinc4 not clamped");
  AST_POST_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_type == FT_POST2) |-> cur_period == 16'h0C80) else $error("post filter period");
  AST_AVG3: assert property (@(posedge aclk) disable iff (!aresetn)
    (cur_type == FT_SINC3_AVG && rate_divider_reg == 11'h003) |-> cur_period == 16'h03C0)
    else $error("sinc3 avg period");
  AST_NOTCH: assert property (@(posedge aclk) disable iff (!aresetn)
    extra_notch_option == (type_reg == 4'b0011)) else $error("extra notch flag");
  AST_SETTLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (step_wr && !wr_data[`CTRL_ASYNC_BIT] && cur_type == FT_SINC3) |=> settle_cnt_reg == 3'h2)
    else $error("sinc3 settle count");
  AST_RESET_TYPE: assert property (@(posedge aclk)
    $rose(aresetn) |-> type_reg == 4'h2) else $error("filter type reset");
  AST_SETTLE_ASYNC: assert property (@(posedge aclk) disable iff (!aresetn)
    (step_wr && wr_data[`CTRL_ASYNC_BIT] && cur_type == FT_SINC3) |=> settle_cnt_reg == 3'h3)
    else $error("async step settle count");
  AST_SETTLE_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && !step_wr && !settled_reg && settle_cnt_reg == 3'h0) |=> settled_reg)
    else $error("settled flag not set");
  AST_STEP_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    (step_wr && enable_reg && wr_data[`CTRL_EN_BIT] && !mclk_tick) |=> mcnt_reg == $past(mcnt_reg))
    else $error("step restarted pacing");
  AST_DROP_COUNTED: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv_done && !fifo_in_ready) |=> seq_reg == $past(seq_reg) + 16'h0001)
    else $error("dropped result not counted");
  AST_DRDY_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
    (!data_ready_n && mclk_tick && !conv_done) |=> data_ready_n) else $error("data ready held low too long");
  AST_PRESCALE: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_reg <= PW'(MCLK_DIV - 1)) else $error("main clock divider out of range");
endmodule

//--- conv_pacing_tb.sv
// Self-checking bench for the conversion pacing controller
`timescale 1ns/1ps
`include "pacing_defs.svh"
module conv_pacing_tb;
  import pacing_pkg::*;
  localparam int MDIV = 4;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic [1:0] resp;
  } note_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] sample_data = 32'h0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, data_ready_n, extra_notch_option;
  note_s notes[$];
  int miscompares = 0;
  int checks_done = 0;
  int gap = 0;
  int last_gap = 0;
  int falls = 0;
  logic dr_q = 1'b1;
  // Sweep plan: filter type and divider pairs
  filter_type_e ft[11] = '{FT_SINC3, FT_SINC4, FT_SINC4_AVG, FT_SINC3_AVG, FT_SINC3_NOTCH, FT_SINC3,
                           FT_POST1, FT_POST2, FT_POST3, FT_POST4, FT_SINC3};
  logic [15:0] dv[11] = '{16'h0, 16'h14, 16'h2, 16'hF803, 16'h5, 16'h30,
                          16'h7, 16'h7, 16'h7, 16'h7, 16'hF0};

  always #4 aclk = ~aclk;

  conv_pacing #(.MCLK_DIV(MDIV), .FIFO_DEPTH(4)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sample_data, .data_ready_n, .extra_notch_option
  );

  host_model host_u (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready
  );

  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read data checker: oldest note against each completed read
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected read", 32'h1, 32'h0);
      end else begin
        chk("rdata", s_axi_rdata & notes[0].mask, notes[0].exp);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, notes[0].resp});
        notes.delete(0);
      end
    end
  end

  // Spacing of data ready falling edges in clock cycles
  always @(posedge aclk) begin
    dr_q <= data_ready_n;
    if (dr_q === 1'b1 && data_ready_n === 1'b0) begin
      last_gap <= gap;
      gap <= 1;
      falls <= falls + 1;
    end else begin
      gap <= gap + 1;
    end
  end

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask, input logic [1:0] resp);
    bit ok;
    notes.push_back({exp, mask, resp});
    host_u.rd(a, ok);
    if (!ok) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] resp);
    bit ok;
    logic [1:0] got;
    host_u.wr(a, d, s, got, ok);
    if (!ok) begin
      miscompares++;
      final_report();
    end
    chk("bresp", {30'h0, got}, {30'h0, resp});
  endtask

  task automatic wait_fall(input logic [31:0] exp_gap);
    int f0;
    int n;
    f0 = falls;
    for (n = 0; n < 20000 && falls == f0; n++) begin
      @(posedge aclk);
    end
    if (falls == f0) begin
      miscompares++;
      final_report();
    end
    if (exp_gap != 0) chk("gap", 32'(last_gap), exp_gap);
  endtask

  function automatic logic [31:0] exp_period(input filter_type_e ft, input logic [15:0] raw);
    logic [31:0] d;
    d = {21'h0, raw[10:0]};
    if (d == 32'h0) d = 32'h1;
    if ((ft == FT_SINC4 || ft == FT_SINC4_AVG) && d > 32'hA) d = 32'hA;
    case (ft)
      FT_SINC4_AVG: return 32'h160 * d;
      FT_SINC3_AVG: return 32'h140 * d;
      FT_POST1: return 32'hB80;
      FT_POST2: return 32'hC80;
      FT_POST3: return 32'hF80;
      FT_POST4: return 32'h1280;
      default: return 32'h20 * d;
    endcase
  endfunction

  function automatic logic [31:0] exp_stat(input filter_type_e ft);
    logic [2:0] mn;
    case (ft)
      FT_SINC4: mn = 3'h3;
      FT_SINC3, FT_SINC3_NOTCH: mn = 3'h2;
      FT_SINC4_AVG, FT_SINC3_AVG: mn = 3'h1;
      default: mn = 3'h0;
    endcase
    return {21'h0, ft == FT_SINC3_NOTCH, 4'h0, mn + 3'h1, mn};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] vals[6];
    int i;
    int k;
    void'($urandom(32'hBE84));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_CTRL_OFF, 32'h2, 32'h1F, 2'h0);
    rd(`REG_DIV_OFF, 32'h1, 32'h7FF, 2'h0);
    rd(`REG_PERIOD_OFF, 32'h20, 32'hFFFFFFFF, 2'h0);
    rd(12'h018, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(`REG_PERIOD_OFF, 32'h5, 4'hF, 2'h2);
    $display("test reset_and_map done");
    wr(`REG_DIV_OFF, 32'h8, 4'h3, 2'h0);
    wr(`REG_CTRL_OFF, 32'h12, 4'h1, 2'h0);
    wait_fall(32'h0);
    wait_fall(32'h0);
    for (k = 0; k < 5; k++) rd(`REG_COUNT_OFF, 32'h0, 32'h0, 2'h0);
    rd(`REG_STAT_OFF, 32'h0, 32'h800, 2'h0);
    for (k = 0; k < 6; k++) begin
      vals[k] = $urandom;
      sample_data <= vals[k];
      wait_fall(32'h100 * MDIV);
    end
    for (k = 0; k < 4; k++) begin
      rd(`REG_RESULT_OFF, vals[k], 32'hFFFFFFFF, 2'h0);
      rd(`REG_COUNT_OFF, 32'(k + 2), 32'hFFFFFFFF, 2'h0);
    end
    rd(`REG_STAT_OFF, 32'h0, 32'h800, 2'h0);
    $display("test fifo_fill_drain done");
    for (k = 0; k < 2; k++) begin
      wr(`REG_CTRL_OFF, (k == 0) ? 32'h72 : 32'h32, 4'h1, 2'h0);
      rd(`REG_STAT_OFF, (k == 0) ? 32'hC0 : 32'h80, 32'h3C0, 2'h0);
      repeat (4 - k) wait_fall(32'h100 * MDIV);
      rd(`REG_STAT_OFF, 32'h200, 32'h3C0, 2'h0);
    end
    $display("test step_settle done");
    for (i = 0; i < 11; i++) begin
      wr(`REG_DIV_OFF, {16'h0, dv[i]}, 4'h3, 2'h0);
      wr(`REG_CTRL_OFF, {28'h1, ft[i]}, 4'h1, 2'h0);
      wait_fall((i > 0) ? exp_period(ft[i - 1], dv[i - 1]) * MDIV : 32'h0);
      rd(`REG_PERIOD_OFF, exp_period(ft[i], dv[i]), 32'hFFFFFFFF, 2'h0);
      rd(`REG_STAT_OFF, exp_stat(ft[i]), 32'h43F, 2'h0);
      chk("notch", {31'h0, extra_notch_option}, {31'h0, ft[i] == FT_SINC3_NOTCH});
    end
    $display("test filter_sweep done");
    repeat (2) @(posedge aclk);
    final_report();
  end
endmodule

//--- host_model.sv
// Host processor model: AXI4-Lite master that reaches the pacing registers
`timescale 1ns/1ps
module host_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Each channel is released at the edge where its ready is seen high
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp, output bit ok);
    bit aw_done;
    bit w_done;
    int n;
    aw_done = 0;
    w_done = 0;
    ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 1000 && !ok; n++) begin
      @(posedge aclk);
      aw_done = aw_done || s_axi_awready;
      w_done = w_done || s_axi_wready;
      s_axi_awvalid <= !aw_done;
      s_axi_wvalid <= !w_done;
      resp = s_axi_bresp;
      ok = s_axi_bvalid;
      s_axi_bready <= !ok;
    end
  endtask

  task automatic rd(input logic [11:0] a, output bit ok);
    bit ar_done;
    int n;
    ar_done = 0;
    ok = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 1000 && !ok; n++) begin
      @(posedge aclk);
      ar_done = ar_done || s_axi_arready;
      s_axi_arvalid <= !ar_done;
      ok = s_axi_rvalid;
      s_axi_rready <= !ok;
    end
  endtask
endmodule

//--- pacing_defs.svh
// Constants for the conversion pacing block
`ifndef PACING_DEFS_SVH
`define PACING_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define REG_CTRL_OFF 12'h000
`define REG_DIV_OFF 12'h004
`define REG_STAT_OFF 12'h008
`define REG_PERIOD_OFF 12'h00C
`define REG_RESULT_OFF 12'h010
`define REG_COUNT_OFF 12'h014

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_TYPE_LSB 0
`define CTRL_EN_BIT 4
`define CTRL_STEP_BIT 5
`define CTRL_ASYNC_BIT 6
`define TYPE_RESET 4'h2
`define DIV_RESET 11'h001
`define DIV_MAX_SINC4 11'h00A

// ****************************************
// Clock rates, and timing figures in main-clock cycles
// ****************************************
`define MCLK_HZ 76800
`define ACLK_HZ 125000000
`define MCLK_DIV ((`ACLK_HZ + `MCLK_HZ - 1) / `MCLK_HZ)
`define MUL_STD 16'h0020
`define MUL_AVG4 16'h0160
`define MUL_AVG3 16'h0140
`define POST1_CYC 16'h0B80
`define POST2_CYC 16'h0C80
`define POST3_CYC 16'h0F80
`define POST4_CYC 16'h1280

`endif

//--- pacing_pkg.sv
// Types for the conversion pacing block
package pacing_pkg;
  typedef enum logic [3:0] {
    FT_SINC4 = 4'b0000,
    FT_SINC4_AVG = 4'b0001,
    FT_SINC3 = 4'b0010,
    FT_SINC3_NOTCH = 4'b0011,
    FT_SINC3_AVG = 4'b0100,
    FT_POST1 = 4'b0101,
    FT_POST2 = 4'b0110,
    FT_POST3 = 4'b0111,
    FT_POST4 = 4'b1000
  } filter_type_e;

  typedef struct packed {
    logic [2:0] settle_min;
    logic [2:0] settle_max;
    logic notch_extra;
  } settle_info_s;

  typedef struct packed {
    logic [31:0] data;
    logic [15:0] seq;
  } result_s;
endpackage

//--- result_fifo.sv
// Small flip-flop FIFO for conversion results
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
